// ---- hw/lp2_state_machine.sv ----
`timescale 1ns/1ps
`default_nettype none
module lp2_state_machine
	import lp2_pkg::*;
(
	// System
	input wire logic clk,
	input wire logic rstn,
	// Memory pins from the controller
	input wire logic ck,
	input wire logic cke,
	input wire logic csN,
	input wire logic [CA_W-1:0] ca,
	// Device and bank state
	output var lp2_dev_t devState,
	output var lp2_bank_t [NBANK-1:0] bankState,
	output logic exitWait,
	output logic initDone,
	// Mode register read data
	output logic [OP_W-1:0] mrrData,
	output logic mrrValid
);
	////////////////////////////////////////////////////////////////////////
	// Pin sampling and link clock edges
	lp2_pins_t pinsRaw;
	lp2_pins_t pins;
	logic ckDly_q;
	logic ckRise;
	logic ckFall;
	logic ckePrev_q;
	logic hh;
	logic hl;
	logic lh;

	assign pinsRaw = {ck, cke, csN, ca};

	lp2_sync #(
		.W($bits(lp2_pins_t))
	) uSync (
		.clk(clk),
		.rstn(rstn),
		.d(pinsRaw),
		.q(pins)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ckDly_q <= 1'h0;
		end else begin
			ckDly_q <= pins.ck;
		end
	end

	// All pins share one synchroniser depth, so they stay aligned to ck
	assign ckRise = pins.ck & ~ckDly_q;
	assign ckFall = ~pins.ck & ckDly_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ckePrev_q <= CKE_RST;
		end else if (ckRise) begin
			ckePrev_q <= pins.cke;
		end
	end

	assign hh = ckePrev_q & pins.cke;
	assign hl = ckePrev_q & ~pins.cke;
	assign lh = ~ckePrev_q & pins.cke;

	////////////////////////////////////////////////////////////////////////
	// Command decode and qualifiers
	lp2_dev_t devState_q;
	lp2_bank_t bankState_q [NBANK];
	logic [TMR_W-1:0] devTmr_q;
	logic [TMR_W-1:0] exitTmr_q;
	logic [TMR_W-1:0] initTmr_q;
	logic initRun_q;
	logic initDone_q;
	lp2_cmd_t cmd;
	logic [BA_W-1:0] ba;
	logic allIdle;
	logic noBurst;
	logic accept;
	logic run;
	logic mrwStart;
	logic mrrStart;
	logic refAbStart;
	logic dpdExit;
	logic mrwPend_q;
	logic mrrPend_q;
	logic [MALO_W-1:0] maLo_q;
	logic [MA_W-1:0] maFull;
	logic mrwFall;
	logic resetGo;
	logic memWe;
	logic mrrRd;
	logic mrrValid_q;
	logic [BA_W-1:0] lastBank_q;
	logic [BA_W-1:0] refPtr_q;

	assign cmd = lp2_decode(pins.csN, pins.ca[3:0]);
	assign ba = pins.ca[CA_BA_LSB +: BA_W];

	always_comb begin
		allIdle = 1'h1;
		noBurst = 1'h1;
		for (int i = 0; i < NBANK; i++) begin
			if (bankState_q[i] != BK_IDLE) begin
				allIdle = 1'h0;
			end
			if (bankState_q[i] != BK_IDLE && bankState_q[i] != BK_ACT) begin
				noBurst = 1'h0;
			end
		end
	end

	// Commands during the exit wait are not acted on
	assign accept = ckRise & hh & ~pins.csN & (exitTmr_q == '0);
	assign run = accept & (devState_q == DEV_RUN);
	assign mrwStart = accept & (cmd == CMD_MRW) &
		((devState_q == DEV_RUN & allIdle) | devState_q == DEV_PWRON);
	assign mrrStart = accept & (cmd == CMD_MRR) &
		((devState_q == DEV_RUN & noBurst) | devState_q == DEV_RESET);
	assign refAbStart = run & (cmd == CMD_REFAB) & allIdle;
	assign dpdExit = ckRise & lh & pins.csN & (devState_q == DEV_DPD);

	// Second half of MRW/MRR arrives on the falling ck edge
	assign maFull = {pins.ca[CA_MAHI_LSB +: 2], maLo_q};
	assign mrwFall = ckFall & mrwPend_q;
	assign resetGo = mrwFall & (maFull == RESET_MA);
	assign memWe = mrwFall & ~resetGo;
	assign mrrRd = ckFall & mrrPend_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mrwPend_q <= 1'h0;
			mrrPend_q <= 1'h0;
			maLo_q <= '0;
			mrrValid_q <= 1'h0;
		end else begin
			mrrValid_q <= mrrRd;
			if (mrwStart || mrrStart) begin
				maLo_q <= pins.ca[CA_MALO_LSB +: MALO_W];
			end
			if (mrwStart) begin
				mrwPend_q <= 1'h1;
			end else if (ckFall) begin
				mrwPend_q <= 1'h0;
			end
			if (mrrStart) begin
				mrrPend_q <= 1'h1;
			end else if (ckFall) begin
				mrrPend_q <= 1'h0;
			end
		end
	end

	lp2_mr_mem uMr (
		.clk(clk),
		.rstn(rstn),
		.we(memWe),
		.waddr(maFull),
		.wdata(pins.ca[CA_OP_LSB +: OP_W]),
		.re(mrrRd),
		.raddr(maFull),
		.rdata(mrrData)
	);

	////////////////////////////////////////////////////////////////////////
	// Initialisation timer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			initTmr_q <= '0;
			initRun_q <= 1'h0;
			initDone_q <= 1'h0;
		end else if (resetGo) begin
			initTmr_q <= TINIT5_CYC;
			initRun_q <= 1'h1;
			initDone_q <= 1'h0;
		end else if (dpdExit) begin
			initRun_q <= 1'h0;
			initDone_q <= 1'h0;
		end else if (initRun_q) begin
			if (initTmr_q == '0) begin
				initRun_q <= 1'h0;
				initDone_q <= 1'h1;
			end else begin
				initTmr_q <= initTmr_q - 1'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Device power state
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			devState_q <= DEV_RST_VAL;
			devTmr_q <= '0;
			exitTmr_q <= '0;
		end else begin
			if (devTmr_q != '0) begin
				devTmr_q <= devTmr_q - 1'h1;
			end
			if (exitTmr_q != '0) begin
				exitTmr_q <= exitTmr_q - 1'h1;
			end
			if (ckRise && hl) begin
				if (devState_q == DEV_RUN && pins.csN) begin
					devState_q <= allIdle ? DEV_PD_IDLE : DEV_PD_ACT;
				end else if (devState_q == DEV_RUN && allIdle &&
					(cmd == CMD_REFPB || cmd == CMD_REFAB)) begin
					devState_q <= DEV_SREF;
				end else if (devState_q == DEV_RUN && allIdle &&
					(cmd == CMD_PRE || cmd == CMD_BST)) begin
					devState_q <= DEV_DPD;
				end else if (devState_q == DEV_RESET && pins.csN) begin
					devState_q <= DEV_PD_RST;
				end
			end else if (ckRise && lh && pins.csN) begin
				unique case (devState_q)
					DEV_PD_ACT, DEV_PD_IDLE: begin
						devState_q <= DEV_RUN;
						exitTmr_q <= TXP_CYC;
					end
					DEV_PD_RST: begin
						devState_q <= initDone_q ? DEV_RUN : DEV_RESET;
						exitTmr_q <= TXP_CYC;
					end
					DEV_SREF: begin
						devState_q <= DEV_RUN;
						exitTmr_q <= TXSR_CYC;
					end
					DEV_DPD: begin
						devState_q <= DEV_PWRON;
					end
					// Rising CKE from a running state is an illegal sequence
					default: begin
					end
				endcase
			end else if (mrwStart && devState_q == DEV_RUN) begin
				devState_q <= DEV_MRW;
				devTmr_q <= TMRW_CYC;
			end else if (mrrStart) begin
				devTmr_q <= TMRR_CYC;
				if (devState_q == DEV_RESET) begin
					devState_q <= DEV_MRR_RST;
				end else if (allIdle) begin
					devState_q <= DEV_MRR_IDLE;
				end else begin
					devState_q <= DEV_MRR_ACT;
				end
			end else if (refAbStart) begin
				devState_q <= DEV_REFALL;
				devTmr_q <= TRFCAB_CYC;
			end else if (resetGo) begin
				devState_q <= DEV_RESET;
			end else if (devTmr_q == '0) begin
				unique case (devState_q)
					DEV_MRW, DEV_MRR_IDLE, DEV_MRR_ACT, DEV_MRR_RST,
					DEV_REFALL: begin
						devState_q <= DEV_RUN;
					end
					DEV_RESET: begin
						if (initDone_q) begin
							devState_q <= DEV_RUN;
						end
					end
					// Power-on and run wait for commands; low-power states wait for CKE to rise
					DEV_PWRON, DEV_RUN, DEV_PD_ACT, DEV_PD_IDLE, DEV_PD_RST,
					DEV_SREF, DEV_DPD: begin
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Burst tracking and per-bank refresh pointer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lastBank_q <= '0;
			refPtr_q <= '0;
		end else begin
			if (run && (cmd == CMD_RD || cmd == CMD_WR)) begin
				lastBank_q <= ba;
			end
			if (run && cmd == CMD_REFPB && bankState_q[refPtr_q] == BK_IDLE) begin
				refPtr_q <= refPtr_q + 1'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bank state machines
	for (genvar b = 0; b < NBANK; b++) begin : gBank
		logic [TMR_W-1:0] tmr_q;
		logic hit;
		logic preHit;
		logic refHit;
		logic bstHit;

		assign hit = (ba == BA_W'(b));
		assign preHit = (cmd == CMD_PRE) & (pins.ca[CA_AB_BIT] | hit);
		assign refHit = (cmd == CMD_REFPB) & (refPtr_q == BA_W'(b));
		assign bstHit = (cmd == CMD_BST) & (lastBank_q == BA_W'(b));

		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				bankState_q[b] <= BK_RST_VAL;
				tmr_q <= '0;
			end else begin
				if (tmr_q != '0) begin
					tmr_q <= tmr_q - 1'h1;
				end
				if (resetGo) begin
					bankState_q[b] <= BK_IDLE;
					tmr_q <= '0;
				end else if (run) begin
					unique case (bankState_q[b])
						BK_IDLE: begin
							if (cmd == CMD_ACT && hit) begin
								bankState_q[b] <= BK_ACT;
							end else if (refHit) begin
								bankState_q[b] <= BK_REF;
								tmr_q <= TRFCPB_CYC;
							end else if (preHit) begin
								bankState_q[b] <= BK_PRE;
								tmr_q <= TRP_CYC;
							end
						end
						BK_ACT: begin
							if (cmd == CMD_RD && hit) begin
								bankState_q[b] <= BK_RD;
								tmr_q <= TBURST_CYC;
							end else if (cmd == CMD_WR && hit) begin
								bankState_q[b] <= BK_WR;
								tmr_q <= TBURST_CYC;
							end else if (preHit) begin
								bankState_q[b] <= BK_PRE;
								tmr_q <= TRP_CYC;
							end
						end
						BK_RD, BK_WR: begin
							if (cmd == CMD_RD && hit) begin
								bankState_q[b] <= BK_RD;
								tmr_q <= TBURST_CYC;
							end else if (cmd == CMD_WR && hit) begin
								bankState_q[b] <= BK_WR;
								tmr_q <= TBURST_CYC;
							end else if (bstHit) begin
								bankState_q[b] <= BK_ACT;
								tmr_q <= '0;
							end
						end
						// Busy banks take only NOP from the controller
						BK_PRE, BK_REF: begin
						end
					endcase
				end else if (tmr_q == '0) begin
					unique case (bankState_q[b])
						BK_PRE, BK_REF: begin
							bankState_q[b] <= BK_IDLE;
						end
						BK_RD, BK_WR: begin
							bankState_q[b] <= BK_ACT;
						end
						BK_IDLE, BK_ACT: begin
						end
					endcase
				end
			end
		end

		assign bankState[b] = bankState_q[b];
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign devState = devState_q;
	assign exitWait = (exitTmr_q != '0);
	assign initDone = initDone_q;
	assign mrrValid = mrrValid_q;
endmodule : lp2_state_machine
`default_nettype wire

// ---- hw/lp2_pkg.sv ----
package lp2_pkg;
	////////////////////////////////////////////////////////////////////////
	// Sizes and CA bus field positions
	localparam int CLK_NS = 10;
	localparam int NBANK = 8;
	localparam int BA_W = 3;
	localparam int CA_W = 10;
	localparam int MA_W = 8;
	localparam int MALO_W = 6;
	localparam int OP_W = 8;
	localparam int TMR_W = 10;
	localparam int CA_BA_LSB = 7;
	localparam int CA_MALO_LSB = 4;
	localparam int CA_MAHI_LSB = 0;
	localparam int CA_OP_LSB = 2;
	localparam int CA_AB_BIT = 4;
	localparam logic [MA_W-1:0] RESET_MA = 8'h3F;
	localparam logic CKE_RST = 1'h0;

	////////////////////////////////////////////////////////////////////////
	// Timing, in ns, and derived clk counts (least times round up)
	localparam int TRP_NS = 18;
	localparam int TRFCPB_NS = 60;
	localparam int TRFCAB_NS = 130;
	localparam int TMRR_NS = 20;
	localparam int TMRW_NS = 50;
	localparam int TXP_NS = 8;
	localparam int TXSR_NS = 140;
	localparam int TBURST_NS = 30;
	localparam int TINIT5_NS = 2000;
	localparam logic [TMR_W-1:0] TRP_CYC =
		TMR_W'((TRP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] TRFCPB_CYC =
		TMR_W'((TRFCPB_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] TRFCAB_CYC =
		TMR_W'((TRFCAB_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] TMRR_CYC =
		TMR_W'((TMRR_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] TMRW_CYC =
		TMR_W'((TMRW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] TXP_CYC =
		TMR_W'((TXP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] TXSR_CYC =
		TMR_W'((TXSR_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] TBURST_CYC =
		TMR_W'((TBURST_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] TINIT5_CYC =
		TMR_W'((TINIT5_NS + CLK_NS - 1) / CLK_NS);

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [12:0] {
		DEV_PWRON = 13'h0001,
		DEV_RESET = 13'h0002,
		DEV_RUN = 13'h0004,
		DEV_MRW = 13'h0008,
		DEV_MRR_IDLE = 13'h0010,
		DEV_MRR_ACT = 13'h0020,
		DEV_MRR_RST = 13'h0040,
		DEV_REFALL = 13'h0080,
		DEV_PD_ACT = 13'h0100,
		DEV_PD_IDLE = 13'h0200,
		DEV_PD_RST = 13'h0400,
		DEV_SREF = 13'h0800,
		DEV_DPD = 13'h1000
	} lp2_dev_t;

	typedef enum logic [5:0] {
		BK_IDLE = 6'h01,
		BK_ACT = 6'h02,
		BK_RD = 6'h04,
		BK_WR = 6'h08,
		BK_PRE = 6'h10,
		BK_REF = 6'h20
	} lp2_bank_t;

	typedef enum logic [9:0] {
		CMD_MRW = 10'h001,
		CMD_MRR = 10'h002,
		CMD_REFPB = 10'h004,
		CMD_REFAB = 10'h008,
		CMD_ACT = 10'h010,
		CMD_WR = 10'h020,
		CMD_RD = 10'h040,
		CMD_PRE = 10'h080,
		CMD_BST = 10'h100,
		CMD_NOP = 10'h200
	} lp2_cmd_t;

	localparam lp2_dev_t DEV_RST_VAL = DEV_PWRON;
	localparam lp2_bank_t BK_RST_VAL = BK_IDLE;

	typedef struct packed {
		logic ck;
		logic cke;
		logic csN;
		logic [CA_W-1:0] ca;
	} lp2_pins_t;

	// Rising-edge command code from CA0..CA3; deselect reads as NOP
	function automatic lp2_cmd_t lp2_decode(input logic csN,
		input logic [3:0] op);
		lp2_cmd_t c;
		c = CMD_NOP;
		if (csN) begin
			c = CMD_NOP;
		end else if (!op[0] && !op[1]) begin
			if (op[2]) begin
				c = op[3] ? CMD_REFAB : CMD_REFPB;
			end else begin
				c = op[3] ? CMD_MRR : CMD_MRW;
			end
		end else if (!op[0]) begin
			c = CMD_ACT;
		end else if (!op[1]) begin
			c = op[2] ? CMD_RD : CMD_WR;
		end else if (!op[2]) begin
			c = op[3] ? CMD_PRE : CMD_BST;
		end
		return c;
	endfunction : lp2_decode
endpackage : lp2_pkg

// ---- hw/lp2_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module lp2_sync #(
	parameter int W = 1
) (
	// System
	input wire logic clk,
	input wire logic rstn,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	for (genvar i = 0; i < W; i++) begin : gBit
		logic meta_q;
		logic sync_q;
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				meta_q <= 1'h0;
				sync_q <= 1'h0;
			end else begin
				meta_q <= d[i];
				sync_q <= meta_q;
			end
		end
		assign q[i] = sync_q;
	end
endmodule : lp2_sync
`default_nettype wire

// ---- hw/lp2_mr_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module lp2_mr_mem
	import lp2_pkg::*;
(
	// System
	input wire logic clk,
	input wire logic rstn,
	// Write port
	input wire logic we,
	input wire logic [MA_W-1:0] waddr,
	input wire logic [OP_W-1:0] wdata,
	// Read port, data one cycle after re
	input wire logic re,
	input wire logic [MA_W-1:0] raddr,
	output logic [OP_W-1:0] rdata
);
	logic [OP_W-1:0] mem [2**MA_W];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 8'h00;
		end else if (re) begin
			rdata <= mem[raddr];
		end
	end
endmodule : lp2_mr_mem
`default_nettype wire

// ---- bench/lp2_state_machine_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module lp2_state_machine_asserts
	import lp2_pkg::*;
(
	// System
	input wire logic clk,
	input wire logic rstn,
	// Link pins
	input wire logic ck,
	input wire logic cke,
	input wire logic csN,
	input wire logic [CA_W-1:0] ca,
	// State and read data
	input wire lp2_dev_t devState,
	input wire lp2_bank_t [NBANK-1:0] bankState,
	input wire logic exitWait,
	input wire logic initDone,
	input wire logic [OP_W-1:0] mrrData,
	input wire logic mrrValid
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	logic [TMR_W-1:0] waitCnt_q;
	wire logic lowPow;
	assign lowPow = devState inside {DEV_PD_ACT, DEV_PD_IDLE, DEV_PD_RST,
		DEV_SREF, DEV_DPD};
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			waitCnt_q <= '0;
		end else begin
			waitCnt_q <= exitWait ? waitCnt_q + 1'b1 : '0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Pins reach state 4 clk after the ck rise, so cke is judged there
	a_low_enter: assert property ($changed(devState) && lowPow |-> !$past(cke, 4))
		else $error("low-power entry without cke low");
	a_low_keep: assert property ($changed(devState) && $past(lowPow) |-> $past(cke, 4))
		else $error("low-power state left with cke low");
	a_exit_wait: assert property ((devState inside {DEV_PD_ACT, DEV_PD_IDLE, DEV_SREF})
		##1 devState == DEV_RUN |-> exitWait)
		else $error("exit without exit wait");
	a_wait_len: assert property ($fell(exitWait) |->
		waitCnt_q == TXP_CYC || waitCnt_q == TXSR_CYC)
		else $error("exit wait of wrong length");
	a_wait_hold: assert property (exitWait |=> $stable(bankState))
		else $error("bank moved during exit wait");
	a_pdrst_exit: assert property (devState == DEV_PD_RST ##1 devState != DEV_PD_RST
		|-> (initDone ? devState == DEV_RUN : devState == DEV_RESET))
		else $error("resetting power-down exit wrong");
	a_dpd_exit: assert property (devState == DEV_DPD ##1 devState != DEV_DPD
		|-> devState == DEV_PWRON && !initDone)
		else $error("deep power-down exit wrong");
	a_mrr_len: assert property ($rose(devState == DEV_MRR_IDLE) |->
		(devState == DEV_MRR_IDLE) [*3] ##1 devState == DEV_RUN)
		else $error("idle register read length wrong");
	a_mrr_pulse: assert property (mrrValid |=> !mrrValid)
		else $error("read data valid too long");
	a_mrw_len: assert property ($rose(devState == DEV_MRW) |-> (devState == DEV_MRW) [*6]
		##1 devState inside {DEV_RUN, DEV_RESET})
		else $error("register write length wrong");
	a_init_run: assert property ($rose(initDone) && devState == DEV_RESET
		|=> devState == DEV_RUN)
		else $error("init end did not reach idle");
	for (genvar b = 0; b < NBANK; b++) begin : g_bank
		a_idle_next: assert property ($past(bankState[b]) == BK_IDLE && bankState[b] != BK_IDLE
			|-> bankState[b] inside {BK_ACT, BK_PRE, BK_REF})
			else $error("idle bank left wrongly");
		a_pre_len: assert property ($rose(bankState[b] == BK_PRE) |->
			(bankState[b] == BK_PRE) [*3] ##1 bankState[b] == BK_IDLE)
			else $error("precharge length wrong");
		a_ref_len: assert property ($rose(bankState[b] == BK_REF) |->
			(bankState[b] == BK_REF) [*7] ##1 bankState[b] == BK_IDLE)
			else $error("refresh length wrong");
		a_rd_end: assert property ($rose(bankState[b] == BK_RD) |->
			(bankState[b] == BK_RD) [*4] ##[1:2] bankState[b] == BK_ACT)
			else $error("read burst length wrong");
	end
	c_sref: cover property (devState == DEV_SREF ##1 devState == DEV_RUN);
	c_mrr: cover property (mrrValid);
	c_wait: cover property ($fell(exitWait));
endmodule : lp2_state_machine_asserts
bind lp2_state_machine lp2_state_machine_asserts u_asserts (.clk(clk), .rstn(rstn),
	.ck(ck), .cke(cke), .csN(csN), .ca(ca), .devState(devState),
	.bankState(bankState), .exitWait(exitWait), .initDone(initDone),
	.mrrData(mrrData), .mrrValid(mrrValid));
`default_nettype wire

// ---- bench/lp2_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lp2_ctrl_model
	import lp2_pkg::*;
(
	// Link to the device
	output logic ck,
	output logic cke,
	output logic csN,
	output logic [CA_W-1:0] ca
);
	initial begin
		ck = 1'b0;
		cke = 1'b0;
		csN = 1'b1;
		ca = '0;
	end
	// One 125 ns period; 1 ns lead keeps every change off the clk edges
	task automatic issue(input logic k, input logic cs, input logic [CA_W-1:0] r,
		input logic [CA_W-1:0] f);
		#1;
		cke = k;
		csN = cs;
		ca = r;
		#31;
		ck = 1'b1;
		#31;
		ca = f;
		#31;
		ck = 1'b0;
		#30;
		// Hold time over: do not leave the old value standing
		ca = ~f;
		#1;
	endtask : issue
endmodule : lp2_ctrl_model
`default_nettype wire

// ---- bench/lp2_state_machine_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define LP2_CHECK(nm, e, g) \
	begin \
		checks++; \
		if ((g) !== (e)) begin \
			miscompares++; \
			$display("BAD %s expected %h seen %h", nm, e, g); \
		end \
	end
module lp2_state_machine_tb_top;
	import lp2_pkg::*;
	typedef struct packed {
		lp2_dev_t dev;
		lp2_bank_t [NBANK-1:0] bank;
	} lp2_snap_t;
	localparam int RUN_NS = 90 * 125;
	logic clk;
	logic rstn;
	wire logic ck;
	wire logic cke;
	wire logic csN;
	wire logic [CA_W-1:0] ca;
	lp2_dev_t devState;
	lp2_bank_t [NBANK-1:0] bankState;
	logic exitWait;
	logic initDone;
	logic [OP_W-1:0] mrrData;
	logic mrrValid;
	int miscompares = 0;
	int checks = 0;
	logic [31:0] lfsr = 32'h3A177289;
	lp2_snap_t expSnap;
	lp2_snap_t lastSnap;
	lp2_snap_t want;
	logic [OP_W-1:0] mrrWant;
	lp2_snap_t snapQ[$];
	logic [OP_W-1:0] mrrQ[$];
	lp2_ctrl_model u_ctrl (.ck(ck), .cke(cke), .csN(csN), .ca(ca));
	lp2_state_machine DUT (.clk(clk), .rstn(rstn), .ck(ck), .cke(cke),
		.csN(csN), .ca(ca), .devState(devState), .bankState(bankState),
		.exitWait(exitWait), .initDone(initDone), .mrrData(mrrData),
		.mrrValid(mrrValid));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd
	task automatic expect_dev(input lp2_dev_t d);
		expSnap.dev = d;
		snapQ.push_back(expSnap);
	endtask : expect_dev
	task automatic expect_bank(input int b, input lp2_bank_t s);
		expSnap.bank[b] = s;
		snapQ.push_back(expSnap);
	endtask : expect_bank
	task automatic expect_all(input lp2_bank_t s);
		for (int b = 0; b < NBANK; b++) begin
			expSnap.bank[b] = s;
		end
		snapQ.push_back(expSnap);
	endtask : expect_all
	task automatic nop(input logic k, input int n);
		logic [31:0] v;
		repeat (n) begin
			v = rnd();
			u_ctrl.issue(k, 1'b1, v[9:0], v[19:10]);
		end
	endtask : nop
	// Unused row and column bits carry random values
	task automatic bank_cmd(input logic [3:0] op, input logic [2:0] b,
		input logic ca4);
		logic [31:0] v;
		v = rnd();
		u_ctrl.issue(1'b1, 1'b0, {b, v[1:0], ca4, op}, v[13:4]);
	endtask : bank_cmd
	task automatic mr_cmd(input logic [3:0] op, input logic [MA_W-1:0] ma,
		input logic [OP_W-1:0] d);
		u_ctrl.issue(1'b1, 1'b0, {ma[5:0], op}, {d, ma[7:6]});
	endtask : mr_cmd
	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////////
	// Every state change must match the oldest expected snapshot
	always @(negedge clk) begin
		if (rstn === 1'b1 && {devState, bankState} !== lastSnap) begin
			lastSnap = {devState, bankState};
			if (snapQ.size() == 0) begin
				miscompares++;
				$display("BAD state expected %h seen %h", expSnap, lastSnap);
			end else begin
				want = snapQ.pop_front();
				`LP2_CHECK("state", want, lastSnap)
			end
		end
		if (mrrValid === 1'b1 && mrrQ.size() > 0) begin
			mrrWant = mrrQ.pop_front();
			`LP2_CHECK("mrrData", mrrWant, mrrData)
		end
	end
	initial begin
		#(RUN_NS * 2);
		miscompares++;
		complete_run();
	end
	initial begin
		rstn = 1'b0;
		expSnap = {DEV_RST_VAL, {NBANK{BK_RST_VAL}}};
		lastSnap = expSnap;
		repeat (6) @(posedge clk);
		@(negedge clk) rstn = 1'b1;
		repeat (3) @(negedge clk);
		`LP2_CHECK("devState", DEV_PWRON, devState)
		`LP2_CHECK("initDone", 1'b0, initDone)
		nop(1'b1, 2);
		expect_dev(DEV_RESET);
		mr_cmd(4'h0, RESET_MA, 8'h00);
		expect_dev(DEV_PD_RST);
		nop(1'b0, 3);
		expect_dev(DEV_RESET);
		nop(1'b1, 2);
		expect_dev(DEV_PD_RST);
		nop(1'b0, 18);
		expect_dev(DEV_RUN);
		nop(1'b1, 2);
		$display("test reset and resetting power-down done");
		expect_dev(DEV_MRW);
		expect_dev(DEV_RUN);
		mr_cmd(4'h0, 8'h05, 8'hA5);
		mrrQ.push_back(8'hA5);
		expect_dev(DEV_MRR_IDLE);
		expect_dev(DEV_RUN);
		mr_cmd(4'h8, 8'h05, 8'h00);
		expect_bank(2, BK_ACT);
		bank_cmd(4'h2, 3'h2, 1'b0);
		expect_bank(7, BK_ACT);
		bank_cmd(4'h2, 3'h7, 1'b1);
		bank_cmd(4'h2, 3'h2, 1'b0);
		mrrQ.push_back(8'hA5);
		expect_dev(DEV_MRR_ACT);
		expect_dev(DEV_RUN);
		mr_cmd(4'h8, 8'h05, 8'h00);
		$display("test register access and activate done");
		expect_bank(2, BK_RD);
		expect_bank(2, BK_ACT);
		bank_cmd(4'h5, 3'h2, 1'b0);
		expect_bank(2, BK_WR);
		expect_bank(2, BK_ACT);
		bank_cmd(4'h1, 3'h2, 1'b0);
		bank_cmd(4'h3, 3'h5, 1'b0);
		expect_dev(DEV_PD_ACT);
		nop(1'b0, 3);
		expect_dev(DEV_RUN);
		nop(1'b1, 2);
		expect_bank(2, BK_PRE);
		expect_bank(2, BK_IDLE);
		bank_cmd(4'hB, 3'h2, 1'b0);
		expect_all(BK_PRE);
		expect_all(BK_IDLE);
		bank_cmd(4'hB, 3'h0, 1'b1);
		$display("test bursts, power-down and precharge done");
		for (int b = 0; b < 2; b++) begin
			expect_bank(b, BK_REF);
			expect_bank(b, BK_IDLE);
			bank_cmd(4'h4, 3'h6, 1'b0);
		end
		expect_dev(DEV_SREF);
		u_ctrl.issue(1'b0, 1'b0, 10'h004, 10'h3FF);
		nop(1'b0, 2);
		expect_dev(DEV_RUN);
		nop(1'b1, 1);
		// Sent inside the exit wait on purpose: it must be dropped
		bank_cmd(4'h2, 3'h3, 1'b0);
		expect_bank(3, BK_ACT);
		bank_cmd(4'h2, 3'h3, 1'b0);
		expect_bank(3, BK_PRE);
		expect_bank(3, BK_IDLE);
		bank_cmd(4'hB, 3'h3, 1'b0);
		expect_dev(DEV_DPD);
		u_ctrl.issue(1'b0, 1'b0, 10'h003, 10'h155);
		nop(1'b0, 2);
		expect_dev(DEV_PWRON);
		nop(1'b1, 2);
		`LP2_CHECK("initDone", 1'b0, initDone)
		$display("test refresh, self refresh and deep power-down done");
		// Reinitialise after deep power-down; init ends while resetting
		expect_dev(DEV_RESET);
		expect_dev(DEV_RUN);
		mr_cmd(4'h0, RESET_MA, 8'h00);
		nop(1'b1, 17);
		`LP2_CHECK("initDone", 1'b1, initDone)
		$display("test reinitialisation done");
		`LP2_CHECK("pending states", 0, snapQ.size())
		`LP2_CHECK("pending reads", 0, mrrQ.size())
		complete_run();
	end
endmodule : lp2_state_machine_tb_top
`default_nettype wire
